// ---- rtl/podl_pkg.sv ----
// Package with the register map, field positions and reset values of the pin output data latch.
package podl_pkg;

  // Data width of the register bus and of the latch.
  localparam int unsigned DATA_W = 32;

  // Width of the byte address seen by the block.
  localparam int unsigned ADR_W = 8;

  // Byte addresses of the registers.
  localparam logic [7:0] OFS_FUNC_SELECT = 8'h10;
  localparam logic [7:0] OFS_DIRECTION = 8'h14;
  localparam logic [7:0] OFS_OUTPUT_LATCH = 8'h18;
  localparam logic [7:0] OFS_SET_ALIAS = 8'h20;
  localparam logic [7:0] OFS_CLEAR_ALIAS = 8'h24;

  // Bits that exist in hardware; bits 24 down to 16 are reserved.
  localparam logic [31:0] IMPL_MASK = 32'hfe00ffff;

  // Values after reset.
  localparam logic [31:0] LATCH_RESET = 32'h00000000;
  localparam logic [31:0] DIRECTION_RESET = 32'h00000000;
  localparam logic [31:0] FUNC_RESET = 32'h00000000;

  // Value returned for an unmapped address.
  localparam logic [31:0] UNMAPPED_DATA = 32'h00000000;

  // Field positions of the control pins, reserved field and serial data pins within every pin register.
  localparam int unsigned BIT_RX_FRAME_SYNC = 31;
  localparam int unsigned BIT_RX_HIGH_RATE_CLK = 30;
  localparam int unsigned BIT_RX_BIT_CLK = 29;
  localparam int unsigned BIT_TX_FRAME_SYNC = 28;
  localparam int unsigned BIT_TX_HIGH_RATE_CLK = 27;
  localparam int unsigned BIT_TX_BIT_CLK = 26;
  localparam int unsigned BIT_MUTE = 25;
  localparam int unsigned RESERVED_MSB = 24;
  localparam int unsigned RESERVED_LSB = 16;
  localparam int unsigned SERIAL_DATA_MSB = 15;
  localparam int unsigned SERIAL_DATA_LSB = 0;

endpackage

// ---- rtl/podl_wb_slave.sv ----
// Classic Wishbone slave front end: address decode, write strobes, byte lane mask and acknowledge.
`timescale 1ns/100ps
module podl_wb_slave #(
  parameter int unsigned ADR_W = 8
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  output logic wb_ack_o,
  output logic req_new,
  output logic hit_func,
  output logic hit_dir,
  output logic hit_latch,
  output logic hit_set,
  output logic hit_clear,
  output logic wr_func,
  output logic wr_dir,
  output logic wr_latch,
  output logic wr_set,
  output logic wr_clear,
  output logic [31:0] lane_mask
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode.

  // Acknowledge flop; it drops in the cycle after it was given.
  logic ack_r;
  logic ack_nxt;
  // Low byte of the address, compared against the map.
  logic [7:0] adr_lo;

  assign adr_lo = wb_adr_i[7:0];
  // A request is taken once, in the cycle before its acknowledge.
  assign req_new = wb_cyc_i & wb_stb_i & ~ack_r;
  assign hit_func = (adr_lo == podl_pkg::OFS_FUNC_SELECT);
  assign hit_dir = (adr_lo == podl_pkg::OFS_DIRECTION);
  assign hit_latch = (adr_lo == podl_pkg::OFS_OUTPUT_LATCH);
  assign hit_set = (adr_lo == podl_pkg::OFS_SET_ALIAS);
  assign hit_clear = (adr_lo == podl_pkg::OFS_CLEAR_ALIAS);
  assign wr_func = req_new & wb_we_i & hit_func;
  assign wr_dir = req_new & wb_we_i & hit_dir;
  assign wr_latch = req_new & wb_we_i & hit_latch;
  assign wr_set = req_new & wb_we_i & hit_set;
  assign wr_clear = req_new & wb_we_i & hit_clear;
  // Each select bit opens its byte lane; closed lanes keep their bits.
  assign lane_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  // Every access, mapped or not, is answered so the bus never hangs.
  assign ack_nxt = req_new;
  assign wb_ack_o = ack_r;

  // Acknowledge register, one cycle after the request is seen.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= ack_nxt;
    end
  end

endmodule

// ---- rtl/podl_pin_drive.sv ----
// Per-pin output stage: registered level and output enable for each pin.
`timescale 1ns/100ps
module podl_pin_drive #(
  parameter int unsigned PIN_N = 32
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [PIN_N-1:0] latch_bits,
  input wire logic [PIN_N-1:0] func_bits,
  input wire logic [PIN_N-1:0] dir_bits,
  output logic [PIN_N-1:0] pin_out,
  output logic [PIN_N-1:0] pin_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // One output stage per pin.

  genvar gi;
  generate
    for (gi = 0; gi < PIN_N; gi++) begin : g_pin
      // Enable only for a general-purpose pin set as output.
      wire drive_en = func_bits[gi] & dir_bits[gi];
      // Per-pin flops; each one feeds a single bit of the output vectors.
      logic out_r;
      logic oe_r;
      // Registered so the pins change one clock after the latch, glitch free.
      always_ff @(posedge core_clk) begin
        if (!nrst) begin
          out_r <= 1'b0;
          oe_r <= 1'b0;
        end else begin
          out_r <= latch_bits[gi];
          oe_r <= drive_en;
        end
      end
      // One continuous driver per bit, so no output bit has two writers.
      assign pin_out[gi] = out_r;
      assign pin_oe[gi] = oe_r;
    end
  endgenerate

endmodule

// ---- rtl/podl_top.sv ----
// Top of the pin output data latch: registers, read path, pin stage and checks.
//
// Local design decision: the Wishbone slave port.
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Latch always holds value, readable anytime.
// - Direction or function writes keep latch.
// - Drive pin only if general-purpose and output.
// - Read returns latch; direct write loads it.
// - Set alias sets bits written one.
// - Clear alias clears bits written one.
// - All three addresses share one latch.
// - Bits 24..16 read zero, ignore writes.
// - Bits 31..25 map the control pins.
// - Bits 15..0 map serial data pins.
// - All latch bits reset to zero.
// - Direction zero means input, never driven.
module podl_top #(
  parameter int unsigned ADR_W = podl_pkg::ADR_W
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [31:0] pin_out,
  output logic [31:0] pin_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  // The single output latch behind all three write addresses.
  logic [31:0] latch_r;
  logic [31:0] latch_nxt;
  // Pin direction bits, one means output.
  logic [31:0] dir_r;
  logic [31:0] dir_nxt;
  // Function select bits, one means general-purpose use.
  logic [31:0] func_r;
  logic [31:0] func_nxt;
  // Registered read data.
  logic [31:0] rdat_r;
  logic [31:0] rdat_nxt;
  // Strobes and decode from the bus front end.
  logic req_new;
  logic hit_func;
  logic hit_dir;
  logic hit_latch;
  logic hit_set;
  logic hit_clear;
  logic wr_func;
  logic wr_dir;
  logic wr_latch;
  logic wr_set;
  logic wr_clear;
  logic [31:0] lane_mask;
  // Bits a write may touch: open byte lanes that exist in hardware.
  logic [31:0] wr_mask;
  // Bits selected for setting or clearing by the alias writes.
  logic [31:0] set_bits;
  logic [31:0] clear_bits;
  // Latch value after a direct load of the open lanes.
  logic [31:0] load_value;
  // Read data picked by address.
  logic [31:0] rd_value;

  ////////////////////////////////////////////////////////////////////////////
  // Bus front end.

  // Decodes the address and answers every access after one cycle.
  podl_wb_slave #(
    .ADR_W(ADR_W)
  ) u_slave (
    .core_clk(core_clk),
    .nrst(nrst),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_ack_o(wb_ack_o),
    .req_new(req_new),
    .hit_func(hit_func),
    .hit_dir(hit_dir),
    .hit_latch(hit_latch),
    .hit_set(hit_set),
    .hit_clear(hit_clear),
    .wr_func(wr_func),
    .wr_dir(wr_dir),
    .wr_latch(wr_latch),
    .wr_set(wr_set),
    .wr_clear(wr_clear),
    .lane_mask(lane_mask)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-value logic for the latch.

  // Reserved bits are masked out of every write, so they stay zero.
  assign wr_mask = lane_mask & podl_pkg::IMPL_MASK;
  assign load_value = (latch_r & ~wr_mask) | (wb_dat_i & wr_mask);
  assign set_bits = wb_dat_i & wr_mask;
  assign clear_bits = wb_dat_i & wr_mask;

  // All three addresses steer the same storage; only the write rule differs.
  // Direction and function writes are absent here, so they never touch it.
  assign latch_nxt = wr_latch ? load_value :
                     wr_set ? (latch_r | set_bits) :
                     wr_clear ? (latch_r & ~clear_bits) :
                     latch_r;

  // Direction and function select share the same lane and reserved masking.
  assign dir_nxt = wr_dir ? ((dir_r & ~wr_mask) | (wb_dat_i & wr_mask)) : dir_r;
  assign func_nxt = wr_func ? ((func_r & ~wr_mask) | (wb_dat_i & wr_mask)) : func_r;

  ////////////////////////////////////////////////////////////////////////////
  // Read path.

  // Reads of the latch and its aliases give the stored bits, never pin levels.
  // Unmapped addresses read as zero and are still acknowledged.
  assign rd_value = (hit_latch | hit_set | hit_clear) ? latch_r :
                    hit_dir ? dir_r :
                    hit_func ? func_r :
                    podl_pkg::UNMAPPED_DATA;
  // Sample only when a request is taken, so data stays put during ack.
  assign rdat_nxt = (req_new & ~wb_we_i) ? rd_value : rdat_r;
  assign wb_dat_o = rdat_r;

  ////////////////////////////////////////////////////////////////////////////
  // Storage.

  // Latch register; everything clears at reset.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      latch_r <= podl_pkg::LATCH_RESET;
    end else begin
      latch_r <= latch_nxt;
    end
  end

  // Direction and function registers; reset leaves every pin an input.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      dir_r <= podl_pkg::DIRECTION_RESET;
      func_r <= podl_pkg::FUNC_RESET;
    end else begin
      dir_r <= dir_nxt;
      func_r <= func_nxt;
    end
  end

  // Read data register.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rdat_r <= podl_pkg::UNMAPPED_DATA;
    end else begin
      rdat_r <= rdat_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin stage.

  // Bit n of each register belongs to pin n: control pins at the top,
  // serial data pins at the bottom. Reserved bits never get an enable.
  podl_pin_drive #(
    .PIN_N(podl_pkg::DATA_W)
  ) u_pins (
    .core_clk(core_clk),
    .nrst(nrst),
    .latch_bits(latch_r),
    .func_bits(func_r),
    .dir_bits(dir_r),
    .pin_out(pin_out),
    .pin_oe(pin_oe)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  // A write request and its acknowledge in the next cycle.
  sequence s_write_latch;
    wr_latch ##1 wb_ack_o;
  endsequence

  sequence s_write_set;
    wr_set ##1 wb_ack_o;
  endsequence

  sequence s_write_clear;
    wr_clear ##1 wb_ack_o;
  endsequence

  // Acknowledge comes one cycle after a taken request and lasts one cycle.
  a_ack_one_cycle: assert property (req_new |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single pulse one cycle after request");

  // Direct load: open implemented lanes take data, others hold.
  a_direct_write_load: assert property (s_write_latch |->
    latch_r == (($past(latch_r) & ~$past(wr_mask)) | ($past(wb_dat_i) & $past(wr_mask))))
    else $error("direct write did not load the latch");

  // Set alias: selected bits become one, nothing else moves.
  a_set_alias_bits: assert property (s_write_set |->
    ((latch_r & $past(set_bits)) == $past(set_bits)) &&
    (((latch_r ^ $past(latch_r)) & ~$past(set_bits)) == 32'h00000000))
    else $error("set alias changed the wrong bits");

  // Clear alias: selected bits become zero, nothing else moves.
  a_clear_alias_bits: assert property (s_write_clear |->
    ((latch_r & $past(clear_bits)) == 32'h00000000) &&
    (((latch_r ^ $past(latch_r)) & ~$past(clear_bits)) == 32'h00000000))
    else $error("clear alias changed the wrong bits");

  // Reserved bits never hold a one.
  a_reserved_bits_zero: assert property ((latch_r & ~podl_pkg::IMPL_MASK) == 32'h00000000)
    else $error("reserved latch bit is set");

  // Latch is clear right after reset.
  a_reset_latch_clear: assert property ($rose(nrst) |-> latch_r == 32'h00000000)
    else $error("latch not clear after reset");

  // Direction and function writes leave the latch as it was.
  a_dir_keeps_latch: assert property ((wr_dir || wr_func) |=> $stable(latch_r))
    else $error("direction or function write disturbed the latch");

  // Reads through any latch address return the stored bits.
  a_read_returns_latch: assert property ((req_new && !wb_we_i && (hit_latch || hit_set || hit_clear))
    |=> wb_dat_o == $past(latch_r))
    else $error("latch read returned wrong data");

  // Enable follows function and direction both at one, a clock later.
  a_pin_enable_gate: assert property (1'b1 |=> pin_oe == ($past(func_r) & $past(dir_r)))
    else $error("pin enable does not match function and direction");

  // A pin set as input is never driven.
  a_input_not_driven: assert property (1'b1 |=> (pin_oe & ~$past(dir_r)) == 32'h00000000)
    else $error("input pin is being driven");

  // Pin level follows the latch one clock later.
  a_pin_level_follow: assert property (1'b1 |=> pin_out == $past(latch_r))
    else $error("pin level does not follow the latch");

  // Without any write the latch keeps its value.
  a_latch_holds: assert property (!(wr_latch || wr_set || wr_clear) |=> $stable(latch_r))
    else $error("latch changed without a write");

  // A read through one of the two alias addresses and its acknowledge.
  sequence s_read_alias;
    (req_new && !wb_we_i && (hit_set || hit_clear)) ##1 wb_ack_o;
  endsequence

  // Alias addresses read back the one shared latch, not a copy of their own.
  a_alias_read_latch: assert property (s_read_alias |-> wb_dat_o == $past(latch_r))
    else $error("alias read did not return the latch");

  // Read data holds between reads, so a slow master still sees the right word.
  a_read_data_holds: assert property (!(req_new && !wb_we_i) |=> $stable(wb_dat_o))
    else $error("read data changed without a read");

  // Reserved positions always read back as zero, whatever was written.
  a_read_reserved_zero: assert property ((wb_dat_o & ~podl_pkg::IMPL_MASK) == 32'h00000000)
    else $error("reserved bit read back as one");

  // A reserved position has no pad, so it never gets an enable.
  a_reserved_no_enable: assert property ((pin_oe & ~podl_pkg::IMPL_MASK) == 32'h00000000)
    else $error("reserved position has an output enable");

  // Closed byte lanes keep their latch bits on every kind of latch write.
  a_closed_lane_keeps: assert property ((wr_latch || wr_set || wr_clear) |=>
    ((latch_r ^ $past(latch_r)) & ~$past(wr_mask)) == 32'h00000000)
    else $error("latch write changed a closed lane");

  // A write to an unmapped address changes no register at all.
  a_unmapped_write_kept: assert property ((req_new && wb_we_i &&
    !(hit_func || hit_dir || hit_latch || hit_set || hit_clear)) |=>
    $stable(latch_r) && $stable(dir_r) && $stable(func_r))
    else $error("unmapped write changed a register");

  // Every acknowledge answers a request taken one cycle earlier.
  a_ack_after_request: assert property (wb_ack_o |-> $past(req_new))
    else $error("ack without a taken request");

  // Straight out of reset no pad is driven and every level is low.
  a_reset_pins_quiet: assert property ($rose(nrst) |->
    (pin_oe == 32'h00000000) && (pin_out == 32'h00000000))
    else $error("pins not quiet after reset");

  // Direction writes honour byte lanes and reserved bits as the latch does.
  a_dir_lane_keeps: assert property (wr_dir |=>
    ((dir_r ^ $past(dir_r)) & ~$past(wr_mask)) == 32'h00000000)
    else $error("direction write changed a closed lane");

endmodule

// ---- tb/podl_board_pins.sv ----
// Board-side model of the pins: resolves each pad from the block's drive and a board pull.
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// A pad that nobody drives sits at the pull level, never at the last driven value.
// This exposes a pin that is enabled when it should not be.
module podl_board_pins #(
  parameter logic PULL_LEVEL = 1'b1
) (
  input wire logic [31:0] pin_out,
  input wire logic [31:0] pin_oe,
  output logic [31:0] pad
);
  // Wire level of each pad, seen by the bench.
  assign pad = (pin_oe & pin_out) | (~pin_oe & {32{PULL_LEVEL}});
endmodule

// ---- tb/tb_pin_output_data_latch.sv ----
// Self-checking testbench for the pin output data latch.
`timescale 1ns/100ps
module tb_pin_output_data_latch;
  logic core_clk, nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, pin_out, pin_oe, pad;
  logic [31:0] latch_m, dir_m, func_m; // Bench copies of the three registers.
  logic [31:0] rd_q[$]; // Expected read data, oldest first.
  int n_errors, tests_run, seed;
  localparam logic PULL = 1'b1; // Board pull level on an undriven pad.
  localparam logic [7:0] ADRS [6] = '{podl_pkg::OFS_FUNC_SELECT, podl_pkg::OFS_DIRECTION,
    podl_pkg::OFS_OUTPUT_LATCH, podl_pkg::OFS_SET_ALIAS, podl_pkg::OFS_CLEAR_ALIAS, 8'h1c};

  ////////////////////////////////////////////////////////////////////////////////
  podl_top #(.ADR_W(podl_pkg::ADR_W)) dut (.core_clk(core_clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_out(pin_out), .pin_oe(pin_oe));
  podl_board_pins #(.PULL_LEVEL(PULL)) board (.pin_out(pin_out), .pin_oe(pin_oe), .pad(pad));

  // Free-running 125 MHz clock.
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Compares one value, counting it and reporting a mismatch at once.
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Expected read data for an address, from the bench copies.
  function automatic logic [31:0] rd_exp(input logic [7:0] a);
    case (a)
      podl_pkg::OFS_FUNC_SELECT: return func_m;
      podl_pkg::OFS_DIRECTION: return dir_m;
      podl_pkg::OFS_OUTPUT_LATCH, podl_pkg::OFS_SET_ALIAS, podl_pkg::OFS_CLEAR_ALIAS: return latch_m;
      default: return podl_pkg::UNMAPPED_DATA;
    endcase
  endfunction

  // Applies a taken write to the bench copies; closed lanes and reserved bits stay as they are.
  task automatic mirror_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] m;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & podl_pkg::IMPL_MASK;
    case (a)
      podl_pkg::OFS_FUNC_SELECT: func_m = (func_m & ~m) | (d & m);
      podl_pkg::OFS_DIRECTION: dir_m = (dir_m & ~m) | (d & m);
      podl_pkg::OFS_OUTPUT_LATCH: latch_m = (latch_m & ~m) | (d & m);
      podl_pkg::OFS_SET_ALIAS: latch_m = latch_m | (d & m);
      podl_pkg::OFS_CLEAR_ALIAS: latch_m = latch_m & ~(d & m);
      default: ;
    endcase
  endtask

  // One classic Wishbone cycle; the request is held until ack is sampled, then idles a cycle.
  task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    if (!we) begin
      rd_q.push_back(rd_exp(a));
    end
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    @(posedge core_clk);
    while (wb_ack_o !== 1'b1 && n < 50) begin
      n++;
      @(posedge core_clk);
    end
    chk("wb_ack_o", 32'h1, {31'h0, wb_ack_o});
    if (we) begin
      mirror_wr(a, d, s);
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge core_clk);
  endtask

  // Pins settle one clock after the ack edge, so they are settled when a transfer returns.
  task automatic check_pins;
    logic [31:0] oe;
    oe = func_m & dir_m;
    chk("pin_oe", oe, pin_oe);
    chk("pin_out", latch_m, pin_out);
    chk("pad", (oe & latch_m) | (~oe & {32{PULL}}), pad);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Read monitor: every read ack takes the oldest expected value off the queue.
  always @(posedge core_clk) begin
    if (nrst === 1'b1 && wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      if (rd_q.size() == 0) begin
        chk("read count", 32'h0, 32'h1);
      end else begin
        chk("wb_dat_o", rd_q.pop_front(), wb_dat_o);
      end
    end
  end

  // Watchdog, far above the thousand or so cycles the sequence needs.
  initial begin
    repeat (20000) @(posedge core_clk);
    $display("wrong value watchdog expected finish seen hang");
    n_errors++;
    test_done();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    logic we;
    logic [7:0] a;
    logic [31:0] d;
    logic [3:0] s;
    seed = 66;
    n_errors = 0;
    tests_run = 0;
    latch_m = '0;
    dir_m = '0;
    func_m = '0;
    nrst <= 1'b0;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    wb_adr_i <= 8'h00;
    wb_sel_i <= 4'h0;
    wb_dat_i <= 32'h0;
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    // Reset values, unmapped address included.
    foreach (ADRS[i]) wb_xfer(1'b0, ADRS[i], 32'h0, 4'hf);
    check_pins();
    // All ones, reserved field included: only implemented bits may take them.
    wb_xfer(1'b1, podl_pkg::OFS_OUTPUT_LATCH, 32'hffffffff, 4'hf);
    wb_xfer(1'b0, podl_pkg::OFS_OUTPUT_LATCH, 32'h0, 4'hf);
    // Direction and function writes must not touch the latch.
    wb_xfer(1'b1, podl_pkg::OFS_DIRECTION, 32'h82000001, 4'hf);
    wb_xfer(1'b1, podl_pkg::OFS_FUNC_SELECT, 32'h80000003, 4'hf);
    wb_xfer(1'b0, podl_pkg::OFS_OUTPUT_LATCH, 32'h0, 4'hf);
    check_pins();
    // Clear then set through the aliases, read through every alias.
    wb_xfer(1'b1, podl_pkg::OFS_CLEAR_ALIAS, 32'hfe00ffff, 4'hf);
    wb_xfer(1'b1, podl_pkg::OFS_SET_ALIAS, 32'h80000001, 4'hf);
    wb_xfer(1'b0, podl_pkg::OFS_SET_ALIAS, 32'h0, 4'hf);
    wb_xfer(1'b0, podl_pkg::OFS_CLEAR_ALIAS, 32'h0, 4'hf);
    check_pins();
    // Random traffic over all addresses; software keeps reserved bits zero.
    repeat (150) begin
      we = ($unsigned($random(seed)) % 3) != 0;
      a = ADRS[$unsigned($random(seed)) % 6];
      d = $random(seed) & podl_pkg::IMPL_MASK;
      s = (($unsigned($random(seed)) % 4) == 0) ? 4'($random(seed)) : 4'hf;
      wb_xfer(we, a, d, s);
      wb_xfer(1'b0, podl_pkg::OFS_OUTPUT_LATCH, 32'h0, 4'hf);
      check_pins();
    end
    // A second reset in mid-run clears everything again.
    nrst <= 1'b0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    latch_m = '0;
    dir_m = '0;
    func_m = '0;
    @(posedge core_clk);
    check_pins();
    foreach (ADRS[i]) wb_xfer(1'b0, ADRS[i], 32'h0, 4'hf);
    test_done();
  end
endmodule
